// [logic/sfio_pkg.sv]
// types shared by the port block
package sfio_pkg;
  typedef enum logic [3:0] {
    SFIO_OP_DIR,
    SFIO_OP_CFG_A,
    SFIO_OP_CFG_B,
    SFIO_OP_WRITE,
    SFIO_OP_READ,
    SFIO_OP_BSET,
    SFIO_OP_BRESET,
    SFIO_OP_BTEST_T,
    SFIO_OP_BTEST_F,
    SFIO_OP_TONE
  } sfio_op_type;
endpackage : sfio_pkg

// [logic/sfio_ports.sv]
// shared-function general-purpose port block
`timescale 1ns/1ps
`include "sfio_regs.svh"
module sfio_ports (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic BACKUP,
  input wire logic CMD_VALID,
  input wire sfio_pkg::sfio_op_type CMD_OP,
  input wire logic [3:0] CMD_PORT,
  input wire logic [1:0] CMD_BIT,
  input wire logic [7:0] CMD_DATA,
  input wire logic [3:0] IRQ_ENABLE,
  input wire logic [43:0] PIN_IN,
  output logic [43:0] PIN_OUT,
  output logic [43:0] PIN_OE_N,
  output logic [3:0] EXT_IRQ,
  output logic [3:0] RD_DATA,
  output logic RD_VALID,
  output logic TEST_TRUE,
  output logic CMD_REJECT
);
  logic [43:0] pin_s1;
  logic [43:0] pin_s2;
  logic bk_s1;
  logic bk_s2;
  logic [43:0] dir;
  logic [43:0] latch;
  logic tone_sel;
  logic [7:0] tone_div;
  logic rst_d;
  logic [43:0] next_out;
  logic [43:0] next_oe_n;
  logic [43:0] view;
  logic [5:0] base;
  logic port_ok;
  logic upper;

  sfio_tone_if tif ();

  sfio_tone u_tone (
    .clk(CLK_SYS),
    .srst(SRST),
    .tif(tif)
  );

  assign tif.enable = tone_sel && !bk_s2;
  assign tif.divisor = tone_div;

  function automatic logic [5:0] port_base(input logic [3:0] p);
    port_base = {p, 2'b00};
  endfunction : port_base

  function automatic logic is_upper(input logic [3:0] p);
    is_upper = (p >= `SFIO_PORT_Q) && (p <= `SFIO_PORT_LAST);
  endfunction : is_upper

  function automatic logic is_od(input int i);
    is_od = i < `SFIO_PIN_J0 + `SFIO_PW;
  endfunction : is_od

  function automatic logic out_only(input int i);
    out_only = is_od(i) || (i >= `SFIO_PIN_N1 && i <= `SFIO_PIN_N3);
  endfunction : out_only

  assign base = port_base(CMD_PORT);
  assign port_ok = CMD_PORT <= `SFIO_PORT_LAST;
  assign upper = is_upper(CMD_PORT);

  // two-stage synchronisers for pins and backup request
  always_ff @(posedge CLK_SYS) begin
    pin_s1 <= PIN_IN;
    pin_s2 <= pin_s1;
    bk_s1 <= BACKUP;
    bk_s2 <= bk_s1;
  end

  always_ff @(posedge CLK_SYS) begin
    rst_d <= SRST;
  end

  // direction registers
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      dir <= {`SFIO_NPORT{`SFIO_DIR_RST}};
    end else if (CMD_VALID && port_ok) begin
      case (CMD_OP)
        sfio_pkg::SFIO_OP_CFG_A: begin
          if (CMD_PORT == `SFIO_PORT_K) begin
            dir[`SFIO_PIN_K0 +: `SFIO_PW] <= CMD_DATA[3:0];
          end
        end
        sfio_pkg::SFIO_OP_CFG_B: begin
          dir[`SFIO_PIN_N0] <= CMD_DATA[`SFIO_CFGB_N0DIR];
        end
        sfio_pkg::SFIO_OP_DIR: begin
          // interrupt and tone ports use their own instructions; the open-drain port has no direction setting
          if (CMD_PORT != `SFIO_PORT_J && CMD_PORT != `SFIO_PORT_K &&
              CMD_PORT != `SFIO_PORT_N) begin
            dir[base +: `SFIO_PW] <= CMD_DATA[3:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // tone role select and tone divisor
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      tone_sel <= 1'b0;
      tone_div <= `SFIO_TONE_DIV_RST;
    end else if (CMD_VALID && CMD_OP == sfio_pkg::SFIO_OP_CFG_B) begin
      tone_sel <= CMD_DATA[`SFIO_CFGB_TONE];
    end else if (CMD_VALID && CMD_OP == sfio_pkg::SFIO_OP_TONE) begin
      tone_div <= CMD_DATA;
    end
  end

  // output latches; written regardless of direction or tone role
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      latch <= {{(`SFIO_NPORT - 1){`SFIO_LATCH_RST}}, `SFIO_LATCH_RST_J};
    end else if (CMD_VALID && port_ok) begin
      case (CMD_OP)
        sfio_pkg::SFIO_OP_WRITE: begin
          latch[base +: `SFIO_PW] <= CMD_DATA[3:0];
        end
        sfio_pkg::SFIO_OP_BSET: begin
          if (!upper) begin
            latch[base + {4'h0, CMD_BIT}] <= 1'b1;
          end
        end
        sfio_pkg::SFIO_OP_BRESET: begin
          if (!upper) begin
            latch[base + {4'h0, CMD_BIT}] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // pin drive; backup floats everything after the sync delay plus the one output register stage
  always_comb begin
    for (int i = 0; i < `SFIO_NPIN; i++) begin
      next_out[i] = latch[i];
      next_oe_n[i] = bk_s2 || !dir[i];
      if (is_od(i)) begin
        next_out[i] = 1'b0;
        next_oe_n[i] = bk_s2 || latch[i];
      end else if (out_only(i)) begin
        next_oe_n[i] = bk_s2;
      end else if (i == `SFIO_PIN_N0 && tone_sel) begin
        next_out[i] = tif.tone;
        next_oe_n[i] = bk_s2;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PIN_OUT <= {`SFIO_NPIN{1'b0}};
      PIN_OE_N <= {`SFIO_NPIN{1'b1}};
    end else begin
      PIN_OUT <= next_out;
      PIN_OE_N <= next_oe_n;
    end
  end

  // read view: output-only bits return the latch; others read 0 in backup, else latch if output, pin if input
  generate
    for (genvar g = 0; g < `SFIO_NPIN; g++) begin : g_view
      if (out_only(g)) begin : g_o
        assign view[g] = latch[g];
      end else begin : g_io
        assign view[g] = !bk_s2 && (dir[g] ? latch[g] : pin_s2[g]);
      end
    end
  endgenerate

  // instruction answers
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      RD_DATA <= 4'h0;
      RD_VALID <= 1'b0;
      TEST_TRUE <= 1'b0;
      CMD_REJECT <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      CMD_REJECT <= 1'b0;
      if (CMD_VALID) begin
        case (CMD_OP)
          sfio_pkg::SFIO_OP_READ: begin
            RD_DATA <= port_ok ? view[base +: `SFIO_PW] : 4'h0;
            RD_VALID <= 1'b1;
          end
          sfio_pkg::SFIO_OP_BSET, sfio_pkg::SFIO_OP_BRESET: begin
            CMD_REJECT <= upper || !port_ok;
          end
          sfio_pkg::SFIO_OP_BTEST_T, sfio_pkg::SFIO_OP_BTEST_F: begin
            if (upper || !port_ok) begin
              CMD_REJECT <= 1'b1;
              TEST_TRUE <= 1'b0;
            end else begin
              TEST_TRUE <= view[base + {4'h0, CMD_BIT}] ^
                           (CMD_OP == sfio_pkg::SFIO_OP_BTEST_F);
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // interrupt request level, gated per pin; relies on input direction
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      EXT_IRQ <= 4'h0;
    end else begin
      EXT_IRQ <= IRQ_ENABLE & ~dir[`SFIO_PIN_K0 +: `SFIO_PW] &
                 pin_s2[`SFIO_PIN_K0 +: `SFIO_PW] & {4{!bk_s2}};
    end
  end

  // checks
  property p_od_low;
    @(posedge CLK_SYS) disable iff (SRST)
    PIN_OUT[`SFIO_PIN_J0 +: `SFIO_PW] == 4'h0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain pin driven high");

  property p_od_release;
    @(posedge CLK_SYS) disable iff (SRST)
    (rst_d || $past(bk_s2)) |-> (&PIN_OE_N[`SFIO_PIN_J0 +: `SFIO_PW]);
  endproperty
  a_od_release: assert property (p_od_release) else $error("open-drain not released");

  property p_irq_gate;
    @(posedge CLK_SYS) disable iff (SRST)
    (EXT_IRQ & ~$past(IRQ_ENABLE)) == 4'h0;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");

  property p_cfg_a;
    @(posedge CLK_SYS) disable iff (SRST)
    (CMD_VALID && CMD_OP == sfio_pkg::SFIO_OP_CFG_A && CMD_PORT == `SFIO_PORT_K)
      |=> ##1 (PIN_OE_N[`SFIO_PIN_K0 +: `SFIO_PW] ==
               ($past(~CMD_DATA[3:0], 2) | {4{bk_s2 && $past(bk_s2)}}) || $past(bk_s2));
  endproperty
  a_cfg_a: assert property (p_cfg_a) else $error("interrupt port direction wrong");

  property p_backup_hiz;
    @(posedge CLK_SYS) disable iff (SRST)
    bk_s2 |=> (&PIN_OE_N) && (RD_DATA == 4'h0 || !RD_VALID ||
               $past(CMD_PORT) == `SFIO_PORT_J || $past(CMD_PORT) == `SFIO_PORT_N);
  endproperty
  a_backup_hiz: assert property (p_backup_hiz) else $error("driver active in backup");

  property p_reset_inputs;
    @(posedge CLK_SYS) disable iff (SRST)
    rst_d |-> (dir == {`SFIO_NPORT{`SFIO_DIR_RST}}) && !tone_sel;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("reset state wrong");

  property p_tone_pin;
    @(posedge CLK_SYS) disable iff (SRST)
    ($past(tone_sel) && !$past(bk_s2)) |-> PIN_OUT[`SFIO_PIN_N0] == $past(tif.tone);
  endproperty
  a_tone_pin: assert property (p_tone_pin) else $error("tone pin not following tone");

  property p_tone_latch;
    @(posedge CLK_SYS) disable iff (SRST)
    (CMD_VALID && CMD_OP == sfio_pkg::SFIO_OP_WRITE && CMD_PORT == `SFIO_PORT_N)
      |=> latch[`SFIO_PIN_N0] == $past(CMD_DATA[0]);
  endproperty
  a_tone_latch: assert property (p_tone_latch) else $error("latch not updated");

  property p_tone_div;
    @(posedge CLK_SYS) disable iff (SRST)
    (CMD_VALID && CMD_OP == sfio_pkg::SFIO_OP_TONE) |=> tone_div == $past(CMD_DATA);
  endproperty
  a_tone_div: assert property (p_tone_div) else $error("tone divisor not loaded");

  property p_companion_out;
    @(posedge CLK_SYS) disable iff (SRST)
    !$past(bk_s2) && !rst_d |-> PIN_OE_N[`SFIO_PIN_N3:`SFIO_PIN_N1] == 3'h0;
  endproperty
  a_companion_out: assert property (p_companion_out) else $error("companion not driven");

  property p_upper_reject;
    @(posedge CLK_SYS) disable iff (SRST)
    (CMD_VALID && upper && (CMD_OP == sfio_pkg::SFIO_OP_BSET ||
     CMD_OP == sfio_pkg::SFIO_OP_BRESET)) |=> CMD_REJECT && $stable(latch);
  endproperty
  a_upper_reject: assert property (p_upper_reject) else $error("bit op on upper port");

  property p_latch_hold;
    @(posedge CLK_SYS) disable iff (SRST)
    !CMD_VALID |=> $stable(latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed by itself");

  c_irq: cover property (@(posedge CLK_SYS) disable iff (SRST) EXT_IRQ != 4'h0);
  c_tone: cover property (@(posedge CLK_SYS) disable iff (SRST)
    tone_sel && $rose(tif.tone));
  c_reject: cover property (@(posedge CLK_SYS) disable iff (SRST) CMD_REJECT);
  c_backup: cover property (@(posedge CLK_SYS) disable iff (SRST) $fell(bk_s2));
endmodule : sfio_ports

// [logic/sfio_regs.svh]
// constants for the shared-function port block
`ifndef SFIO_REGS_SVH
`define SFIO_REGS_SVH

`define SFIO_NPORT 11
`define SFIO_NPIN 44
`define SFIO_PW 4
`define SFIO_PORT_J 4'h0
`define SFIO_PORT_K 4'h1
`define SFIO_PORT_N 4'h4
`define SFIO_PORT_Q 4'h7
`define SFIO_PORT_LAST 4'hA
`define SFIO_PIN_J0 6'h00
`define SFIO_PIN_K0 6'h04
`define SFIO_PIN_N0 6'h10
`define SFIO_PIN_N1 6'h11
`define SFIO_PIN_N3 6'h13
`define SFIO_CFGB_TONE 0
`define SFIO_CFGB_N0DIR 1
`define SFIO_LATCH_RST_J 4'hF
`define SFIO_LATCH_RST 4'h0
`define SFIO_DIR_RST 4'h0
`define SFIO_TONE_DIV_RST 8'hFF
`define SFIO_TONE_PRESCALE 7'h63

`endif

// [logic/sfio_tone.sv]
// tone generator: square wave from a loaded divisor
`timescale 1ns/1ps
`include "sfio_regs.svh"
module sfio_tone (
  input wire logic clk,
  input wire logic srst,
  sfio_tone_if.gen tif
);
  logic [6:0] pre;
  logic [7:0] cnt;
  logic tone;

  assign tif.tone = tone;

  // prescaler divides 40 MHz by 100 down to a 400 kHz base rate
  always_ff @(posedge clk) begin
    if (srst || !tif.enable || pre == `SFIO_TONE_PRESCALE) begin
      pre <= 7'h00;
    end else begin
      pre <= pre + 7'h01;
    end
  end

  // half period = divisor + 1 prescaled ticks
  always_ff @(posedge clk) begin
    if (srst || !tif.enable) begin
      cnt <= 8'h00;
      tone <= 1'b0;
    end else if (pre == `SFIO_TONE_PRESCALE) begin
      if (cnt >= tif.divisor) begin
        cnt <= 8'h00;
        tone <= ~tone;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule : sfio_tone

// [logic/sfio_tone_if.sv]
// carrier between port core and tone generator
`timescale 1ns/1ps
interface sfio_tone_if;
  logic enable;
  logic [7:0] divisor;
  logic tone;
  modport gen (input enable, input divisor, output tone);
  modport ctl (output enable, output divisor, input tone);
endinterface : sfio_tone_if

// [verif/sfio_board.sv]
// board model: pull-ups on open-drain pins, bench drivers elsewhere
`timescale 1ns/1ps
module sfio_board (
  input wire logic clk,
  input wire logic [43:0] pin_out,
  input wire logic [43:0] pin_oe_n,
  input wire logic [43:0] ext_val,
  input wire logic [43:0] ext_en,
  output logic [43:0] pin_in
);
  logic [43:0] last = 44'h000_0000_0000;
  always_ff @(posedge clk) begin
    last <= pin_in;
  end
  // floating pins other than the pulled-up open-drain ones invert every cycle so a stale level never reads as valid
  always_comb begin
    for (int i = 0; i < 44; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (i < 4) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = ~last[i];
      end
    end
  end
endmodule : sfio_board

// [verif/sfio_ports_tb_top.sv]
// self-checking bench for the shared-function port block
`timescale 1ns/1ps
`include "sfio_regs.svh"
module sfio_ports_tb_top;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic backup = 1'b0;
  logic cmd_valid = 1'b0;
  sfio_pkg::sfio_op_type cmd_op = sfio_pkg::SFIO_OP_READ;
  logic [3:0] cmd_port = 4'h0;
  logic [1:0] cmd_bit = 2'h0;
  logic [7:0] cmd_data = 8'h00;
  logic [3:0] irq_enable = 4'h0;
  logic [43:0] ext_val = 44'h000_0000_0000;
  logic [43:0] ext_en = 44'h000_0000_0000;
  logic [43:0] pin_in;
  logic [43:0] pin_out;
  logic [43:0] pin_oe_n;
  logic [3:0] ext_irq;
  logic [3:0] rd_data;
  logic rd_valid;
  logic test_true;
  logic cmd_reject;
  int num_errors = 0;
  int num_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  sfio_ports sfio_ports_inst (.CLK_SYS(clk_sys), .SRST(srst), .BACKUP(backup),
    .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_PORT(cmd_port), .CMD_BIT(cmd_bit),
    .CMD_DATA(cmd_data), .IRQ_ENABLE(irq_enable), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE_N(pin_oe_n), .EXT_IRQ(ext_irq), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .TEST_TRUE(test_true), .CMD_REJECT(cmd_reject));
  sfio_board sfio_board_inst (.clk(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  task automatic chk(input logic [43:0] seen, input logic [43:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle

  // one-cycle strobe; bit ops take the bit number from d[1:0]
  task automatic cmd(input sfio_pkg::sfio_op_type op, input logic [3:0] p, input logic [7:0] d);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_port = p;
    cmd_data = d;
    cmd_bit = d[1:0];
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask : cmd

  task automatic rd(input logic [3:0] p, input logic [3:0] exp);
    int i;
    cmd(sfio_pkg::SFIO_OP_READ, p, 8'h00);
    for (i = 0; i < 4 && rd_valid !== 1'b1; i++) @(negedge clk_sys);
    chk(44'(rd_data), 44'(exp));
    if (i == 4) begin
      chk(44'h1, 44'h0);
      tally_and_finish();
    end
  endtask : rd

  // reject is a one-cycle pulse, so look over a short window
  task automatic bop(input int op, input logic [3:0] p, input logic exp);
    logic seen;
    seen = 1'b0;
    cmd(sfio_pkg::sfio_op_type'(op), p, 8'h00);
    repeat (3) begin
      seen = seen | (cmd_reject === 1'b1);
      @(negedge clk_sys);
    end
    chk(44'(seen), 44'(exp));
  endtask : bop

  task automatic half(input int exp);
    int n;
    logic v;
    v = pin_out[16];
    for (n = 0; n < 700 && pin_out[16] === v; n++) @(negedge clk_sys);
    v = pin_out[16];
    for (n = 0; n < 700 && pin_out[16] === v; n++) @(negedge clk_sys);
    chk(44'(n), 44'(exp));
    if (n == 700) tally_and_finish();
  endtask : half

  task automatic t_reset();
    chk(pin_oe_n, 44'hFFF_FFF1_FFFF);
    chk(44'(pin_in[3:0]), 44'hF);
    chk(44'(ext_irq), 44'h0);
    rd(`SFIO_PORT_J, 4'hF);
  endtask : t_reset

  task automatic t_open_drain();
    cmd(sfio_pkg::SFIO_OP_WRITE, `SFIO_PORT_J, 8'h05);
    idle(3);
    chk(44'(pin_oe_n[3:0]), 44'h5);
    chk(44'(pin_out[3:0]), 44'h0);
    chk(44'(pin_in[3:0]), 44'h5);
  endtask : t_open_drain

  task automatic t_irq();
    ext_en[4] = 1'b1;
    ext_val[4] = 1'b1;
    irq_enable = 4'h1;
    idle(5);
    chk(44'(ext_irq), 44'h1);
    irq_enable = 4'h0;
    idle(3);
    chk(44'(ext_irq), 44'h0);
    // data 8'h0A leaves bit 0 clear, so the enabled pin stays input while pins 5 and 7 go output
    irq_enable = 4'h1;
    cmd(sfio_pkg::SFIO_OP_CFG_A, `SFIO_PORT_K, 8'h0A);
    idle(3);
    chk(44'(pin_oe_n[7:4]), 44'h5);
    chk(44'(ext_irq), 44'h1);
    irq_enable = 4'h0;
    cmd(sfio_pkg::SFIO_OP_CFG_A, `SFIO_PORT_K, 8'h00);
    ext_en[4] = 1'b0;
  endtask : t_irq

  task automatic t_plain();
    cmd(sfio_pkg::SFIO_OP_WRITE, 4'h2, 8'h05);
    idle(3);
    chk(44'(pin_oe_n[11:8]), 44'hF);
    cmd(sfio_pkg::SFIO_OP_DIR, 4'h2, 8'h09);
    idle(3);
    chk(44'(pin_oe_n[15:8]), 44'hF6);
    chk(44'(pin_out[11:8]), 44'h5);
    ext_en[15:12] = 4'hF;
    ext_val[15:12] = 4'hC;
    idle(5);
    rd(4'h3, 4'hC);
  endtask : t_plain

  task automatic t_upper();
    for (int k = 0; k < 4; k++) begin
      bop(int'(sfio_pkg::SFIO_OP_BSET) + k, 4'(7 + k), 1'b1);
    end
    bop(int'(sfio_pkg::SFIO_OP_BTEST_T), 4'h2, 1'b0);
    chk(44'(test_true), 44'h1);
    bop(int'(sfio_pkg::SFIO_OP_BRESET), 4'h2, 1'b0);
    chk(44'(pin_out[11:8]), 44'h4);
    bop(int'(sfio_pkg::SFIO_OP_BTEST_T), 4'h2, 1'b0);
    chk(44'(test_true), 44'h0);
    bop(int'(sfio_pkg::SFIO_OP_BTEST_F), 4'h2, 1'b0);
    chk(44'(test_true), 44'h1);
    bop(int'(sfio_pkg::SFIO_OP_BSET), 4'h2, 1'b0);
    chk(44'(pin_out[11:8]), 44'h5);
    bop(int'(sfio_pkg::SFIO_OP_BSET), 4'hB, 1'b1);
    rd(4'hB, 4'h0);
    cmd(sfio_pkg::SFIO_OP_WRITE, `SFIO_PORT_Q, 8'h06);
    cmd(sfio_pkg::SFIO_OP_DIR, `SFIO_PORT_Q, 8'h0F);
    idle(3);
    chk(44'(pin_out[31:28]), 44'h6);
    rd(`SFIO_PORT_Q, 4'h6);
  endtask : t_upper

  task automatic t_backup();
    backup = 1'b1;
    idle(5);
    chk(pin_oe_n, 44'hFFF_FFFF_FFFF);
    chk(44'(ext_irq), 44'h0);
    rd(4'h3, 4'h0);
    backup = 1'b0;
    idle(5);
    chk(44'(pin_oe_n[11:8]), 44'h6);
  endtask : t_backup

  task automatic t_tone();
    cmd(sfio_pkg::SFIO_OP_TONE, `SFIO_PORT_N, 8'h00);
    cmd(sfio_pkg::SFIO_OP_CFG_B, `SFIO_PORT_N, 8'h01);
    idle(3);
    chk(44'(pin_oe_n[19:16]), 44'h0);
    half(100);
    cmd(sfio_pkg::SFIO_OP_WRITE, `SFIO_PORT_N, 8'h0B);
    idle(3);
    chk(44'(pin_out[19:17]), 44'h5);
    half(100);
    cmd(sfio_pkg::SFIO_OP_TONE, `SFIO_PORT_N, 8'h02);
    half(300);
    cmd(sfio_pkg::SFIO_OP_CFG_B, `SFIO_PORT_N, 8'h02);
    idle(3);
    chk(44'(pin_out[16]), 44'h1);
    rd(`SFIO_PORT_N, 4'hB);
  endtask : t_tone

  initial begin
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    idle(3);
    t_reset();
    t_open_drain();
    t_irq();
    t_plain();
    t_upper();
    t_backup();
    t_tone();
    tally_and_finish();
  end
endmodule : sfio_ports_tb_top
